// ---- include/plc_pkg.sv ----
// shared constants and types of the four-slice logic cluster
// Notes on behaviour
// - four slices, 50 routing inputs, 23 outputs
// - slices 0-2 have flip-flops, slice 3 none
// - memory mode only in the ram-capable variant
// - each lookup answers from a 16-entry table
// - two lookups join into five-input, wider across slices
// - set/reset sync or async, clock and chip select
// - flip-flop clock polarity and edge or latch
// - slices 0-2: 13 routing inputs plus carry
// - slice 3: ten inputs, four outputs, no carry
// - slice 2 gives write address and data
// - write clock is slice clock, enable local set/reset
// - unregistered and wide mux outputs per slice, registered on slices 0-2
// - ripple mode: add, subtract, count, multiply, compare
// - fast carry chain from carry-in to slice 2
// - slices 0 and 1 form 16x4 single port memory
// - companion slice mirrors contents as read-only port
// - both memory forms use three slices
// - memory contents loaded before operation starts
// - rom contents loaded only while configuring
package plc_pkg;
	// register bus
	localparam int PLC_ADDR_W = 8;
	localparam logic [7:0] PLC_ADDR_CTRL = 8'h00;
	localparam logic [7:0] PLC_ADDR_STATUS = 8'h04;
	localparam logic [7:0] PLC_ADDR_LUT_BASE = 8'h20;
	localparam logic [7:0] PLC_ADDR_SCFG_BASE = 8'h40;
	localparam logic [1:0] PLC_RESP_OKAY = 2'h0;
	localparam logic [1:0] PLC_RESP_SLVERR = 2'h2;
	// decoded register kinds
	localparam logic [2:0] PLC_KIND_NONE = 3'h0;
	localparam logic [2:0] PLC_KIND_CTRL = 3'h1;
	localparam logic [2:0] PLC_KIND_STATUS = 3'h2;
	localparam logic [2:0] PLC_KIND_LUT = 3'h3;
	localparam logic [2:0] PLC_KIND_SCFG = 3'h4;
	// control register fields
	localparam int PLC_CTRL_W = 2;
	localparam int PLC_CTRL_DONE = 0;
	localparam int PLC_CTRL_SEL = 1;
	localparam logic [1:0] PLC_CTRL_RST = 2'h0;
	// slice configuration fields
	localparam int PLC_SCFG_W = 13;
	localparam int PLC_SCFG_MODE_LO = 0;
	localparam int PLC_SCFG_CLKINV = 2;
	localparam int PLC_SCFG_LATCH = 3;
	localparam int PLC_SCFG_ASYNC = 4;
	localparam int PLC_SCFG_LSRVAL = 5;
	localparam int PLC_SCFG_CEBYP = 6;
	localparam int PLC_SCFG_FAST = 7;
	localparam int PLC_SCFG_PSEUDO_DUAL_PORT_MEMORY = 8;
	localparam int PLC_SCFG_OP_LO = 9;
	localparam logic [12:0] PLC_SCFG_RST = 13'h0000;
	localparam logic [15:0] PLC_LUT_RST = 16'h0000;
	// slice modes
	localparam logic [1:0] PLC_MODE_LOGIC = 2'h0;
	localparam logic [1:0] PLC_MODE_RIPPLE = 2'h1;
	localparam logic [1:0] PLC_MODE_RAM = 2'h2;
	localparam logic [1:0] PLC_MODE_ROM = 2'h3;
	// ripple operations
	localparam logic [3:0] PLC_OP_ADD = 4'h0;
	localparam logic [3:0] PLC_OP_SUB = 4'h1;
	localparam logic [3:0] PLC_OP_ADDSUB = 4'h2;
	localparam logic [3:0] PLC_OP_UPCNT = 4'h3;
	localparam logic [3:0] PLC_OP_DNCNT = 4'h4;
	localparam logic [3:0] PLC_OP_UDCNT = 4'h5;
	localparam logic [3:0] PLC_OP_MULT = 4'h6;
	localparam logic [3:0] PLC_OP_CMPGE = 4'h7;
	localparam logic [3:0] PLC_OP_CMPNE = 4'h8;
	localparam logic [3:0] PLC_OP_CMPLE = 4'h9;
	// bus states, gray along idle-response-data
	typedef enum logic [1:0] {
		BUS_IDLE = 2'h0,
		BUS_WRESP = 2'h1,
		BUS_RDATA = 2'h3
	} plc_bus_state_t;
endpackage

// ---- include/plc_slice_if.sv ----
// signals between the cluster and one of its slices
`timescale 1ns/1ns
`default_nettype none
interface plc_slice_if;
	logic [15:0] table0; // lookup table of the low lookup
	logic [15:0] table1; // lookup table of the high lookup
	logic [7:0] lutIn; // {D1,C1,B1,A1,D0,C0,B0,A0}
	logic [1:0] mp; // multipurpose inputs {one, zero}
	logic [plc_pkg::PLC_SCFG_W-1:0] cfg; // slice configuration word
	logic [1:0] q; // current flip-flop values
	logic carryIn; // carry from the slice below
	logic [1:0] f; // lookup or ripple result
	logic five; // five-input function
	logic carryOut; // carry to the slice above
	modport cluster (output table0, table1, lutIn, mp, cfg, q, carryIn, input f, five, carryOut);
	modport slice (input table0, table1, lutIn, mp, cfg, q, carryIn, output f, five, carryOut);
endinterface
`default_nettype wire

// ---- core/plc_slice.sv ----
// combinational lookup and ripple logic of one slice
`timescale 1ns/1ns
`default_nettype none
module plc_slice
	import plc_pkg::*;
#(
	parameter bit HAS_RIPPLE = 1'b1
)
(
	// cluster side
	plc_slice_if.slice port
);
	logic lut0, lut1; // table outputs
	logic [1:0] opA, opB, addend; // ripple operands
	logic [2:0] res, tmp; // {carry, sum}
	logic chain, rippleOn, isCount;
	logic [3:0] op;

	// two-bit add by generate and propagate terms
	function automatic logic [2:0] addTwo(input logic [1:0] a, input logic [1:0] b, input logic cin);
		logic [1:0] gen, prop;
		logic c1;
		gen = a & b;
		prop = a ^ b;
		c1 = gen[0] | (prop[0] & cin);
		return {gen[1] | (prop[1] & c1), prop ^ {c1, cin}};
	endfunction

	// table read needs no clock, so memory reads are immediate
	always_comb
	begin
		lut0 = port.table0[port.lutIn[3:0]];
		lut1 = port.table1[port.lutIn[7:4]];
		opA = {port.lutIn[4], port.lutIn[0]};
		opB = {port.lutIn[5], port.lutIn[1]};
		addend = {port.lutIn[7], port.lutIn[3]};
		op = port.cfg[PLC_SCFG_OP_LO +: 4];
		chain = port.cfg[PLC_SCFG_FAST];
		rippleOn = HAS_RIPPLE && (port.cfg[PLC_SCFG_MODE_LO +: 2] == PLC_MODE_RIPPLE);
		isCount = (op == PLC_OP_UPCNT) || (op == PLC_OP_DNCNT) || (op == PLC_OP_UDCNT);
		tmp = 3'h0;
		// outside a chain each operation picks its own carry-in
		case (op)
			PLC_OP_ADD: res = addTwo(opA, opB, chain & port.carryIn);
			PLC_OP_SUB: res = addTwo(opA, ~opB, chain ? port.carryIn : 1'b1);
			PLC_OP_ADDSUB: res = addTwo(opA, port.lutIn[2] ? ~opB : opB,
				chain ? port.carryIn : port.lutIn[2]);
			PLC_OP_UPCNT: res = addTwo(port.q, 2'h0, chain ? port.carryIn : 1'b1);
			PLC_OP_DNCNT: res = addTwo(port.q, 2'h3, chain & port.carryIn);
			PLC_OP_UDCNT: res = addTwo(port.q, port.lutIn[2] ? 2'h3 : 2'h0,
				chain ? port.carryIn : ~port.lutIn[2]);
			PLC_OP_MULT: res = addTwo(addend, opA & {2{port.lutIn[1]}}, chain & port.carryIn);
			PLC_OP_CMPGE:
			begin
				tmp = addTwo(opA, ~opB, chain ? port.carryIn : 1'b1);
				res = {tmp[2], 1'b0, tmp[2]};
			end
			PLC_OP_CMPLE:
			begin
				tmp = addTwo(opB, ~opA, chain ? port.carryIn : 1'b1);
				res = {tmp[2], 1'b0, tmp[2]};
			end
			PLC_OP_CMPNE:
			begin
				tmp[0] = (opA != opB) | (chain & port.carryIn);
				res = {tmp[0], 1'b0, tmp[0]};
			end
			default: res = 3'h0;
		endcase
		// synchronous preload of a counter from the B operand
		if (isCount && port.mp[0])
			res = {1'b0, opB};
		port.f = rippleOn ? res[1:0] : {lut1, lut0};
		port.carryOut = rippleOn & chain & res[2];
		port.five = port.mp[0] ? lut1 : lut0;
	end
endmodule
`default_nettype wire

// ---- core/plc_cluster.sv ----
// four-slice logic cluster with its configuration registers on axi4-lite
//
// Chosen here: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
module plc_cluster
	import plc_pkg::*;
#(
	parameter bit HAS_RAM = 1'b1 // ram-capable variant when set
)
(
	// clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// axi4-lite write
	input wire logic [PLC_ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// axi4-lite read
	input wire logic [PLC_ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// routing inputs
	input wire logic [3:0][7:0] lutIn,
	input wire logic [3:0] multipurposeInZero,
	input wire logic [3:0] multipurposeInOne,
	input wire logic [2:0] clockEnable,
	input wire logic [2:0] localSetReset,
	input wire logic [2:0] sliceClock,
	input wire logic clusterCarryIn,
	// routing outputs
	output logic [3:0][1:0] unregisteredOutputs,
	output logic [2:0][1:0] registeredOutputs,
	output logic [3:0] wideMuxOutLow,
	output logic [3:0] wideMuxOutHigh,
	output logic clusterCarryOut
);
	// whole state of the cluster
	typedef struct packed {
		plc_bus_state_t bus;
		logic awHave; // write address held
		logic wHave; // write data held
		logic [PLC_ADDR_W-1:0] awAddr;
		logic [31:0] wData;
		logic [3:0] wStrb;
		logic awready;
		logic wready;
		logic arready;
		logic bvalid;
		logic rvalid;
		logic [1:0] bresp;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic [PLC_CTRL_W-1:0] ctrl;
		logic [7:0][15:0] lut; // index is slice*2+lookup
		logic [3:0][PLC_SCFG_W-1:0] scfg;
		logic [2:0][1:0] q; // slice flip-flops
		logic [2:0] clkPrev; // sampled slice clocks, polarity applied
		logic [3:0][1:0] fOut;
		logic [3:0] wide_mux_out_low;
		logic [3:0] wide_mux_out_high;
		logic carryOut;
	} plc_cluster_state_t;

	plc_cluster_state_t s_q, s_d;
	plc_slice_if sl[4] ();
	logic [3:0][1:0] sliceF; // per-slice results
	logic [3:0] sliceFive;
	logic [3:0] sliceCout;
	logic [2:0] ramMode; // slice really in memory mode
	logic awGo, wGo, arGo; // handshakes this edge
	logic live; // configured and selected
	logic memClk, memEdge, memWrite;
	logic [3:0] memAddr, memData;
	logic [2:0] clkNow, fire, lsrOn;
	logic six01, six23, seven;
	logic wrBit;

	// byte-lane merge of a register word
	function automatic logic [31:0] mergeStrobe(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++)
			if (strb[b])
				r[8*b +: 8] = nw[8*b +: 8];
		return r;
	endfunction

	// register kind of a byte address, low two bits ignored
	function automatic logic [2:0] decodeKind(input logic [PLC_ADDR_W-1:0] a);
		logic [PLC_ADDR_W-1:0] w;
		w = {a[PLC_ADDR_W-1:2], 2'h0};
		if (w == PLC_ADDR_CTRL)
			return PLC_KIND_CTRL;
		if (w == PLC_ADDR_STATUS)
			return PLC_KIND_STATUS;
		if (w[7:5] == PLC_ADDR_LUT_BASE[7:5])
			return PLC_KIND_LUT;
		if (w[7:4] == PLC_ADDR_SCFG_BASE[7:4])
			return PLC_KIND_SCFG;
		return PLC_KIND_NONE;
	endfunction

	// slices and their chain; slice 3 has neither flops nor carry
	for (genvar g = 0; g < 4; g++)
	begin : gSlice
		assign sl[g].table0 = s_q.lut[2*g];
		assign sl[g].table1 = s_q.lut[2*g+1];
		assign sl[g].lutIn = lutIn[g];
		assign sl[g].mp = {multipurposeInOne[g], multipurposeInZero[g]};
		assign sl[g].cfg = s_q.scfg[g];
		if (g < 3)
		begin : gFlops
			assign sl[g].q = s_q.q[g];
			assign ramMode[g] = HAS_RAM && (s_q.scfg[g][PLC_SCFG_MODE_LO +: 2] == PLC_MODE_RAM);
		end
		else
		begin : gNoFlops
			assign sl[g].q = 2'h0;
		end
		if (g == 0)
		begin : gChainIn
			assign sl[g].carryIn = clusterCarryIn;
		end
		else if (g < 3)
		begin : gChainMid
			assign sl[g].carryIn = sliceCout[g-1];
		end
		else
		begin : gChainNone
			assign sl[g].carryIn = 1'b0;
		end
		assign sliceF[g] = sl[g].f;
		assign sliceFive[g] = sl[g].five;
		assign sliceCout[g] = sl[g].carryOut;
		plc_slice #(.HAS_RIPPLE(g < 3)) uSlice (
			.port(sl[g].slice)
		);
	end

	// handshakes on the valid inputs and the registered ready flags
	assign awGo = awvalid & s_q.awready;
	assign wGo = wvalid & s_q.wready;
	assign arGo = arvalid & s_q.arready;
	assign live = s_q.ctrl[PLC_CTRL_DONE] & s_q.ctrl[PLC_CTRL_SEL];

	// next state of bus, registers, memory and flops
	always_comb
	begin
		s_d = s_q;
		wrBit = 1'b0;
		// bus slave: one answer at a time; a write taken in the same cycle as a read is answered after it
		case (s_q.bus)
			BUS_IDLE:
			begin
				if (awGo)
				begin
					s_d.awHave = 1'b1;
					s_d.awAddr = awaddr;
				end
				if (wGo)
				begin
					s_d.wHave = 1'b1;
					s_d.wData = wdata;
					s_d.wStrb = wstrb;
				end
				if (arGo)
				begin
					// a read is only taken while no write part is held
					s_d.bus = BUS_RDATA;
					s_d.rvalid = 1'b1;
					s_d.rresp = PLC_RESP_OKAY;
					s_d.rdata = 32'h0000_0000;
					case (decodeKind(araddr))
						PLC_KIND_CTRL: s_d.rdata = 32'(s_q.ctrl);
						PLC_KIND_STATUS: s_d.rdata = 32'({HAS_RAM, s_q.ctrl[PLC_CTRL_DONE],
							s_q.carryOut, s_q.q});
						PLC_KIND_LUT: s_d.rdata = 32'(s_q.lut[araddr[4:2]]);
						PLC_KIND_SCFG: s_d.rdata = 32'(s_q.scfg[araddr[3:2]]);
						default: s_d.rresp = PLC_RESP_SLVERR;
					endcase
				end
				else if (s_d.awHave && s_d.wHave)
				begin
					s_d.awHave = 1'b0;
					s_d.wHave = 1'b0;
					s_d.bus = BUS_WRESP;
					s_d.bvalid = 1'b1;
					s_d.bresp = PLC_RESP_OKAY;
					case (decodeKind(s_d.awAddr))
						PLC_KIND_CTRL: s_d.ctrl = PLC_CTRL_W'(mergeStrobe(32'(s_q.ctrl),
							s_d.wData, s_d.wStrb));
						PLC_KIND_LUT:
						begin
							// bus writes to tables and modes are refused once configuration ends
							if (s_q.ctrl[PLC_CTRL_DONE])
								s_d.bresp = PLC_RESP_SLVERR;
							else
								s_d.lut[s_d.awAddr[4:2]] = 16'(mergeStrobe(
									32'(s_q.lut[s_d.awAddr[4:2]]), s_d.wData, s_d.wStrb));
						end
						PLC_KIND_SCFG:
						begin
							if (s_q.ctrl[PLC_CTRL_DONE])
								s_d.bresp = PLC_RESP_SLVERR;
							else
								s_d.scfg[s_d.awAddr[3:2]] = PLC_SCFG_W'(mergeStrobe(
									32'(s_q.scfg[s_d.awAddr[3:2]]), s_d.wData, s_d.wStrb));
						end
						default: s_d.bresp = PLC_RESP_SLVERR;
					endcase
				end
			end
			BUS_WRESP:
			begin
				if (bready)
				begin
					s_d.bvalid = 1'b0;
					s_d.bus = BUS_IDLE;
				end
			end
			BUS_RDATA:
			begin
				if (rready)
				begin
					s_d.rvalid = 1'b0;
					s_d.bus = BUS_IDLE;
				end
			end
			default: s_d.bus = BUS_IDLE;
		endcase
		s_d.awready = (s_d.bus == BUS_IDLE) && !s_d.awHave;
		s_d.wready = (s_d.bus == BUS_IDLE) && !s_d.wHave;
		s_d.arready = (s_d.bus == BUS_IDLE) && !s_d.awHave && !s_d.wHave;

		// distributed memory: slice 2 drives address, data and strobe
		memClk = sliceClock[2] ^ s_q.scfg[2][PLC_SCFG_CLKINV];
		memEdge = memClk & ~s_q.clkPrev[2];
		memAddr = lutIn[2][3:0];
		memData = lutIn[2][7:4];
		memWrite = live && ramMode[2] && memEdge && localSetReset[2];
		for (int j = 0; j < 2; j++)
		begin
			for (int k = 0; k < 2; k++)
			begin
				// mirrored mode feeds the low data pair to the companion
				if (j == 1 && s_q.scfg[2][PLC_SCFG_PSEUDO_DUAL_PORT_MEMORY])
					wrBit = memData[k];
				else
					wrBit = memData[2*j+k];
				if (memWrite && ramMode[j])
					s_d.lut[2*j+k][memAddr] = wrBit;
			end
		end

		// slice flip-flops: polarity, edge or latch, set/reset first
		clkNow = 3'h0;
		fire = 3'h0;
		lsrOn = 3'h0;
		for (int i = 0; i < 3; i++)
		begin
			clkNow[i] = sliceClock[i] ^ s_q.scfg[i][PLC_SCFG_CLKINV];
			s_d.clkPrev[i] = clkNow[i];
			fire[i] = s_q.scfg[i][PLC_SCFG_LATCH] ? clkNow[i] : (clkNow[i] & ~s_q.clkPrev[i]);
			// in memory mode slice 2's set/reset is the write strobe instead
			lsrOn[i] = localSetReset[i] && !(i == 2 && ramMode[2]);
			if (live)
			begin
				if (lsrOn[i] && (s_q.scfg[i][PLC_SCFG_ASYNC] || fire[i]))
					s_d.q[i] = {2{s_q.scfg[i][PLC_SCFG_LSRVAL]}};
				else if (fire[i] && (clockEnable[i] || s_q.scfg[i][PLC_SCFG_CEBYP]))
					s_d.q[i] = sliceF[i];
			end
		end

		// wide functions: six from slice pairs, seven from the sixes
		six01 = multipurposeInOne[0] ? sliceFive[1] : sliceFive[0];
		six23 = multipurposeInOne[2] ? sliceFive[3] : sliceFive[2];
		seven = multipurposeInOne[1] ? six23 : six01;
		s_d.wide_mux_out_high = {multipurposeInOne[3] ? seven : six23, six23, seven, six01};
		s_d.wide_mux_out_low = sliceFive;
		s_d.fOut = sliceF;
		s_d.carryOut = sliceCout[2];
	end

	// one register for the whole state
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			s_q <= '0;
			s_q.bus <= BUS_IDLE;
			s_q.ctrl <= PLC_CTRL_RST;
			s_q.lut <= {8{PLC_LUT_RST}};
			s_q.scfg <= {4{PLC_SCFG_RST}};
		end
		else
			s_q <= s_d;
	end

	// every output straight from the state register
	assign awready = s_q.awready;
	assign wready = s_q.wready;
	assign bvalid = s_q.bvalid;
	assign bresp = s_q.bresp;
	assign arready = s_q.arready;
	assign rvalid = s_q.rvalid;
	assign rdata = s_q.rdata;
	assign rresp = s_q.rresp;
	assign unregisteredOutputs = s_q.fOut;
	assign registeredOutputs = s_q.q;
	assign wideMuxOutLow = s_q.wide_mux_out_low;
	assign wideMuxOutHigh = s_q.wide_mux_out_high;
	assign clusterCarryOut = s_q.carryOut;
endmodule
`default_nettype wire

// ---- tb/plc_fabric_model.sv ----
// routing fabric model that clocks the slices on request
`timescale 1ns/1ns
`default_nettype none
module plc_fabric_model
(
	// fabric clock and requests
	input wire logic mclk,
	input wire logic [2:0] fire,
	// slice clocks toward the cluster
	output logic [2:0] sliceClock
);
	// one high cycle per request, low between requests
	always_ff @(posedge mclk)
	begin
		sliceClock <= fire;
	end
endmodule
`default_nettype wire

// ---- tb/plc_cluster_chk.sv ----
// bus and wide-function assertions of the logic cluster
`timescale 1ns/1ns
`default_nettype none
module plc_cluster_chk
	import plc_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// register bus
	input wire logic [PLC_ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic [PLC_ADDR_W-1:0] araddr,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	input wire logic rready,
	// wide functions
	input wire logic [3:0] multipurposeInOne,
	input wire logic [3:0] wideMuxOutLow,
	input wire logic [3:0] wideMuxOutHigh
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!reset_n);
	// answers stand until taken
	bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write answer dropped early");
	rdata_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read answer dropped early");
	// one cycle from take to answer
	read_answer_a: assert property (arvalid && arready |=> rvalid && !arready)
		else $error("read answer late");
	write_answer_a: assert property (awvalid && awready && wvalid && wready &&
		!(arvalid && arready) |=> bvalid && !awready && !wready)
		else $error("write answer late");
	// refused places
	bad_addr_a: assert property (arvalid && arready && araddr >= 8'h50 |=>
		rresp == PLC_RESP_SLVERR && rdata == 32'h0000_0000)
		else $error("unmapped read not refused");
	ro_write_a: assert property (awvalid && awready && wvalid && wready &&
		awaddr[7:2] == 6'h01 && !(arvalid && arready) |=> bresp == PLC_RESP_SLVERR)
		else $error("status write not refused");
	// joins of five-input results into wider ones
	six_join_a: assert property (wideMuxOutHigh[0] ==
		($past(multipurposeInOne[0]) ? wideMuxOutLow[1] : wideMuxOutLow[0]))
		else $error("six-input join wrong");
	seven_join_a: assert property (wideMuxOutHigh[1] ==
		($past(multipurposeInOne[1]) ? wideMuxOutHigh[2] : wideMuxOutHigh[0]))
		else $error("seven-input join wrong");
	top_join_a: assert property (wideMuxOutHigh[3] ==
		($past(multipurposeInOne[3]) ? wideMuxOutHigh[1] : wideMuxOutHigh[2]))
		else $error("top join wrong");
endmodule
bind plc_cluster plc_cluster_chk i_plc_cluster_chk (.mclk, .reset_n, .awaddr, .awvalid,
	.awready, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
	.rdata, .rresp, .rvalid, .rready, .multipurposeInOne, .wideMuxOutLow, .wideMuxOutHigh);
`default_nettype wire

// ---- tb/tb.sv ----
// self-checking bench of the logic cluster
`timescale 1ns/1ns
`default_nettype none
module tb;
	import plc_pkg::*;
	// clock, reset and bus
	logic mclk, reset_n, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	// fabric side
	logic [3:0][7:0] lutIn;
	logic [3:0] mZero, multipurposeInOne, wideMuxOutLow, wideMuxOutHigh;
	logic [2:0] ce, local_set_reset, fire, sClk;
	logic cin, cout;
	logic [3:0][1:0] uOut;
	logic [2:0][1:0] rOut;
	// bench state
	int error_cnt, n_tests, k, j;
	logic [31:0] rnd, d;
	logic [15:0] tbl [8];
	logic [1:0] r, q;
	logic [3:0] ops [7] = '{PLC_OP_ADD, PLC_OP_SUB, PLC_OP_CMPGE, PLC_OP_CMPNE, PLC_OP_CMPLE,
		PLC_OP_ADDSUB, PLC_OP_MULT};
	plc_cluster i_plc_cluster (.mclk, .reset_n, .awaddr, .awvalid, .awready, .wdata, .wstrb,
		.wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
		.rresp, .rvalid, .rready, .lutIn, .multipurposeInZero(mZero), .multipurposeInOne,
		.clockEnable(ce), .localSetReset(local_set_reset), .sliceClock(sClk), .clusterCarryIn(cin),
		.unregisteredOutputs(uOut), .registeredOutputs(rOut), .wideMuxOutLow,
		.wideMuxOutHigh, .clusterCarryOut(cout));
	plc_fabric_model i_plc_fabric_model (.mclk(mclk), .fire(fire), .sliceClock(sClk));
	// free-running bench clock
	initial
	begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	// next value of the stimulus shift register
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	// expected lookup pair of a slice
	function automatic logic [1:0] lk(input int s, input logic [7:0] x);
		return {tbl[2*s+1][x[7:4]], tbl[2*s][x[3:0]]};
	endfunction
	// expected two-bit ripple result, operands A={A1,A0}, B={B1,B0}
	function automatic logic [1:0] rip(input logic [3:0] op, input logic [7:0] x);
		logic [1:0] a, b;
		a = {x[4], x[0]};
		b = {x[5], x[1]};
		case (op)
			PLC_OP_ADD: return a + b;
			PLC_OP_SUB: return a - b;
			PLC_OP_CMPGE: return {1'b0, a >= b};
			PLC_OP_CMPNE: return {1'b0, a != b};
			// C0 picks subtract, multiply step adds {D1,D0} to A gated by B0
			PLC_OP_ADDSUB: return x[2] ? a - b : a + b;
			PLC_OP_MULT: return {x[7], x[3]} + (a & {2{x[1]}});
			default: return {1'b0, a <= b};
		endcase
	endfunction
	// ends the run with counts and verdict
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic cmp_word(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e)
		begin
			error_cnt++;
			$display("[FAIL] %0t word %h expected %h", $time, g, e);
		end
	endtask
	task automatic cmp_pair(input logic [1:0] g, input logic [1:0] e);
		n_tests++;
		if (g !== e)
		begin
			error_cnt++;
			$display("[FAIL] %0t bits %b expected %b", $time, g, e);
		end
	endtask
	task automatic endt(input string nm);
		$display("test %s done", nm);
	endtask
	// one bus transfer; valids held until their ready, ready held until the answer
	task automatic axi(input bit wr, input logic [7:0] a, input logic [31:0] v);
		int i;
		@(posedge mclk);
		if (wr)
		begin
			awaddr <= a;
			wdata <= v;
			awvalid <= 1'b1;
			wvalid <= 1'b1;
			bready <= 1'b1;
		end
		else
		begin
			araddr <= a;
			arvalid <= 1'b1;
			rready <= 1'b1;
		end
		for (i = 0; i < 50; i++)
		begin
			@(posedge mclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (arready) arvalid <= 1'b0;
			if (wr ? bvalid : rvalid)
			begin
				r = wr ? bresp : rresp;
				d = rdata;
				bready <= 1'b0;
				rready <= 1'b0;
				break;
			end
		end
		// a bus that never answers ends the run
		if (i == 50)
		begin
			error_cnt++;
			$display("[FAIL] %0t bus timeout", $time);
			print_verdict();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] e);
		axi(1'b1, a, v);
		cmp_pair(r, e);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] ev, input logic [1:0] e);
		axi(1'b0, a, 32'h0000_0000);
		cmp_pair(r, e);
		cmp_word(d, ev);
	endtask
	// one slice clock rise through the fabric model, result settled at the end
	task automatic pulse(input int s);
		@(posedge mclk);
		fire[s] <= 1'b1;
		@(posedge mclk);
		fire[s] <= 1'b0;
		repeat (2) @(posedge mclk);
		@(negedge mclk);
	endtask
	// main sequence
	initial
	begin
		{reset_n, awvalid, wvalid, bready, arvalid, rready, cin} = '0;
		{awaddr, araddr, wdata, lutIn, mZero, multipurposeInOne, ce, local_set_reset, fire} = '0;
		wstrb = 4'hf;
		rnd = 32'h0000_65f6;
		repeat (8) @(posedge mclk);
		reset_n <= 1'b1;
		repeat (2) @(posedge mclk);
		rd(PLC_ADDR_STATUS, 32'h0000_0100, PLC_RESP_OKAY);
		rd(PLC_ADDR_CTRL, 32'h0000_0000, PLC_RESP_OKAY);
		rd(8'h60, 32'h0000_0000, PLC_RESP_SLVERR);
		wr(PLC_ADDR_STATUS, 32'hffff_ffff, PLC_RESP_SLVERR);
		endt("registers");
		for (k = 0; k < 8; k++)
		begin
			rnd = lfsr(rnd);
			tbl[k] = rnd[15:0];
			wr(PLC_ADDR_LUT_BASE + 8'(4 * k), {16'h0000, rnd[15:0]}, PLC_RESP_OKAY);
		end
		// random lookup inputs on all slices, joins watched by the checker
		for (k = 0; k < 24; k++)
		begin
			@(posedge mclk);
			rnd = lfsr(rnd);
			lutIn <= rnd;
			mZero <= rnd[3:0] ^ rnd[13:10];
			multipurposeInOne <= rnd[7:4] ^ rnd[27:24];
			cin <= rnd[9];
			@(posedge mclk);
			@(negedge mclk);
			for (j = 0; j < 4; j++)
				cmp_pair(uOut[j], lk(j, lutIn[j]));
		end
		endt("logic");
		for (k = 0; k < 7; k++)
		begin
			wr(8'h44, {19'h0_0000, ops[k], 7'h00, PLC_MODE_RIPPLE}, PLC_RESP_OKAY);
			for (j = 0; j < 8; j++)
			begin
				@(posedge mclk);
				rnd = lfsr(rnd);
				lutIn[1] <= rnd[7:0];
				@(posedge mclk);
				@(negedge mclk);
				cmp_pair(uOut[1], rip(ops[k], lutIn[1]));
				cmp_pair({1'b0, cout}, 2'h0);
			end
		end
		endt("ripple");
		// slice 1 flops with sync set, memory on slices 0 and 2, then lock
		wr(8'h44, 32'h0000_0020, PLC_RESP_OKAY);
		// slice 0 also gets async set/reset with set value one
		wr(8'h40, {24'h00_0000, 6'h0c, PLC_MODE_RAM}, PLC_RESP_OKAY);
		wr(8'h48, {30'h0000_0000, PLC_MODE_RAM}, PLC_RESP_OKAY);
		wr(PLC_ADDR_CTRL, 32'h0000_0003, PLC_RESP_OKAY);
		wr(PLC_ADDR_LUT_BASE, 32'h0000_ffff, PLC_RESP_SLVERR);
		rd(PLC_ADDR_LUT_BASE, {16'h0000, tbl[0]}, PLC_RESP_OKAY);
		@(posedge mclk);
		ce <= 3'h7;
		lutIn[1] <= 8'h5a;
		pulse(1);
		q = lk(1, 8'h5a);
		cmp_pair(rOut[1], q);
		@(posedge mclk);
		ce <= 3'h5;
		lutIn[1] <= 8'ha5;
		pulse(1);
		cmp_pair(rOut[1], q);
		@(posedge mclk);
		local_set_reset <= 3'h2;
		repeat (3) @(posedge mclk);
		@(negedge mclk);
		cmp_pair(rOut[1], q);
		pulse(1);
		cmp_pair(rOut[1], 2'h3);
		// async set/reset needs no slice clock event
		@(posedge mclk);
		local_set_reset <= 3'h1;
		repeat (2) @(posedge mclk);
		@(negedge mclk);
		cmp_pair(rOut[0], 2'h3);
		@(posedge mclk);
		local_set_reset <= 3'h0;
		endt("flops");
		for (k = 0; k < 6; k++)
		begin
			@(posedge mclk);
			rnd = lfsr(rnd);
			lutIn[2] <= rnd[7:0];
			lutIn[0] <= {rnd[3:0], rnd[3:0]};
			local_set_reset <= 3'h4;
			pulse(2);
			tbl[0][rnd[3:0]] = rnd[4];
			tbl[1][rnd[3:0]] = rnd[5];
			@(posedge mclk);
			local_set_reset <= 3'h0;
			@(negedge mclk);
			cmp_pair(uOut[0], {rnd[5], rnd[4]});
			rd(PLC_ADDR_LUT_BASE, {16'h0000, tbl[0]}, PLC_RESP_OKAY);
			rd(PLC_ADDR_LUT_BASE + 8'h04, {16'h0000, tbl[1]}, PLC_RESP_OKAY);
		end
		endt("memory");
		print_verdict();
	end
endmodule
`default_nettype wire
